/* src/pulse_monitor_pkg.sv */
// Package: types and constants of the delayed test pulse monitor
package pulse_monitor_pkg;
   // ---------------------------------------------
   // Timing
   // ---------------------------------------------
   localparam int CLOCK_HZ = 50_000_000;
   localparam int CNT_W = 24;
   // Default pulse interval 10 ms, pulse width 1 ms
   localparam int INTERVAL_US = 10000;
   localparam int WIDTH_US = 1000;
   localparam int INTERVAL_CYC = INTERVAL_US * (CLOCK_HZ / 1_000_000);
   localparam int WIDTH_CYC = WIDTH_US * (CLOCK_HZ / 1_000_000);

   // ---------------------------------------------
   // Configuration carrier
   // ---------------------------------------------
   typedef struct packed {
      logic [CNT_W-1:0] interval;
      logic [CNT_W-1:0] width;
      logic [CNT_W-1:0] delay_min;
      logic [CNT_W-1:0] delay_max;
      logic [CNT_W-1:0] width_min;
      logic [CNT_W-1:0] width_max;
   } monitor_cfg_t;

   // Fault causes, sticky
   typedef struct packed {
      logic missing;
      logic delay_bad;
      logic width_bad;
   } fault_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_SAFE = 3'b100
   } mon_state_t;
endpackage

/* src/edge_timer.sv */
// Edge timer: counts cycles since a start strobe, saturating
`timescale 1ns/100ps
module edge_timer #(
   parameter int W = 24
) (
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic start_in,
   output logic [W-1:0] count_out
);
   initial begin
      if (W < 4) begin
         $error("edge_timer width too small");
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rstn_in || start_in) begin
         count_out <= '0;
      end else if (count_out != {W{1'b1}}) begin
         count_out <= count_out + 1'b1;
      end
   end
endmodule

/* src/delayed_test_pulse_monitor.sv */
// Top: test pulse generator and delayed echo evaluator
`timescale 1ns/100ps
module delayed_test_pulse_monitor
   import pulse_monitor_pkg::*;
#(
   parameter int W = pulse_monitor_pkg::CNT_W
) (
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic enable_in,
   input wire pulse_monitor_pkg::monitor_cfg_t cfg_in,
   input wire logic ack_in,
   input wire logic sink_return_input_in,
   output logic pulse_generation_output_out,
   output logic release_out,
   output logic safe_state_out,
   output pulse_monitor_pkg::fault_t fault_out,
   output logic [W-1:0] measured_delay_out,
   output logic [W-1:0] measured_width_out
);
   import pulse_monitor_pkg::*;

   initial begin
      if (W != CNT_W) begin
         $error("counter width must match package carrier");
      end
   end

   // ---------------------------------------------
   // Input synchroniser and edge detect
   // ---------------------------------------------
   logic ret_meta_reg, ret_sync_reg, ret_prev_reg;
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         ret_meta_reg <= 1'b0;
         ret_sync_reg <= 1'b0;
         ret_prev_reg <= 1'b0;
      end else begin
         ret_meta_reg <= sink_return_input_in;
         ret_sync_reg <= ret_meta_reg;
         ret_prev_reg <= ret_sync_reg;
      end
   end
   logic ret_fall, ret_rise;
   assign ret_fall = ret_prev_reg && !ret_sync_reg;
   assign ret_rise = !ret_prev_reg && ret_sync_reg;

   // ---------------------------------------------
   // State machine
   // ---------------------------------------------
   mon_state_t state_reg, state_next;
   logic verdict_fail;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (enable_in) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (verdict_fail) begin
               state_next = ST_SAFE;
            end else if (!enable_in) begin
               state_next = ST_IDLE;
            end
         end
         ST_SAFE: begin
            if (ack_in) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_SAFE;
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end
   logic running;
   assign running = (state_reg == ST_RUN);

   // ---------------------------------------------
   // Pulse generator
   // ---------------------------------------------
   logic [W-1:0] phase_reg;
   logic period_start;
   assign period_start = running && (phase_reg == '0);
   always_ff @(posedge clock_in) begin
      if (!rstn_in || !running) begin
         phase_reg <= '0;
      end else if (phase_reg >= cfg_in.interval - 1'b1) begin
         phase_reg <= '0;
      end else begin
         phase_reg <= phase_reg + 1'b1;
      end
   end

   // While running, output is high between pulses and low during the pulse width; in idle and safe it is held low
   always_ff @(posedge clock_in) begin
      if (!rstn_in || !running) begin
         pulse_generation_output_out <= 1'b0;
      end else begin
         pulse_generation_output_out <= (phase_reg >= cfg_in.width);
      end
   end

   // ---------------------------------------------
   // Echo measurement
   // ---------------------------------------------
   // The delay timer starts at our own falling edge and the width timer at the
   // returned falling edge, so the delay may be shorter or longer than the width.
   logic [W-1:0] since_gen, since_ret;
   edge_timer #(.W(W)) u_gen_timer (
      .clock_in(clock_in),
      .rstn_in(rstn_in),
      .start_in(period_start),
      .count_out(since_gen)
   );
   edge_timer #(.W(W)) u_ret_timer (
      .clock_in(clock_in),
      .rstn_in(rstn_in),
      .start_in(ret_fall),
      .count_out(since_ret)
   );

   logic echo_seen_reg, started_reg, armed_reg;
   logic delay_bad, width_bad, missing;
   logic [W-1:0] ret_width;
   // Low cycles of the returned pulse, counted from synced fall to synced rise
   assign ret_width = (since_ret == {W{1'b1}}) ? since_ret : since_ret + 1'b1;
   // the delay window covers the summed delay of all sources
   assign delay_bad = running && ret_fall &&
                      (since_gen < cfg_in.delay_min || since_gen > cfg_in.delay_max);
   assign width_bad = running && ret_rise && echo_seen_reg &&
                      (ret_width < cfg_in.width_min || ret_width > cfg_in.width_max);
   // A whole interval without a returned fall means the echo is absent; the first
   // interval after start has no generated fall, so checking begins one later
   assign missing = period_start && armed_reg && !echo_seen_reg && !ret_fall;
   assign verdict_fail = delay_bad || width_bad || missing;

   always_ff @(posedge clock_in) begin
      if (!rstn_in || !running) begin
         echo_seen_reg <= 1'b0;
      end else if (ret_fall) begin
         echo_seen_reg <= 1'b1;
      end else if (period_start) begin
         echo_seen_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rstn_in || !running) begin
         started_reg <= 1'b0;
         armed_reg <= 1'b0;
      end else if (period_start) begin
         started_reg <= 1'b1;
         armed_reg <= started_reg;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         measured_delay_out <= '0;
         measured_width_out <= '0;
      end else begin
         if (running && ret_fall) begin
            measured_delay_out <= since_gen;
         end
         if (running && ret_rise) begin
            measured_width_out <= ret_width;
         end
      end
   end

   // ---------------------------------------------
   // Release and safe state
   // ---------------------------------------------
   // A complete good pulse (delay then width) is needed before release
   logic good_delay_reg;
   always_ff @(posedge clock_in) begin
      if (!rstn_in || !running) begin
         good_delay_reg <= 1'b0;
      end else if (ret_fall) begin
         good_delay_reg <= !delay_bad;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rstn_in || !running || verdict_fail) begin
         release_out <= 1'b0;
      end else if (ret_rise && good_delay_reg && !width_bad) begin
         release_out <= 1'b1;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         safe_state_out <= 1'b0;
         fault_out <= '0;
      end else if (state_next == ST_SAFE) begin
         safe_state_out <= 1'b1;
         fault_out <= fault_out | {missing, delay_bad, width_bad};
      end else begin
         safe_state_out <= 1'b0;
         fault_out <= '0;
      end
   end
endmodule

/* test/delayed_test_pulse_monitor_checker.sv */
// Port checker for the delayed test pulse monitor
`timescale 1ns/100ps
module delayed_test_pulse_monitor_checker
   import pulse_monitor_pkg::*;
#(parameter int W = CNT_W) (
   input wire logic clock_in, rstn_in, enable_in, ack_in, sink_return_input_in,
   input wire pulse_monitor_pkg::monitor_cfg_t cfg_in,
   input wire logic pulse_generation_output_out, release_out, safe_state_out,
   input wire pulse_monitor_pkg::fault_t fault_out,
   input wire logic [W-1:0] measured_delay_out, measured_width_out
);
   int hi_run_reg;
   default clocking @(posedge clock_in);
   endclocking
   default disable iff (!rstn_in);
   // Cycles the generated output has stood high
   always_ff @(posedge clock_in) begin
      hi_run_reg <= (rstn_in && pulse_generation_output_out) ? hi_run_reg + 1 : 0;
   end
   a_release_not_safe: assert property (release_out |-> !safe_state_out)
      else $error("release in safe");
   a_idle_no_release: assert property (!enable_in [*3] |-> !release_out)
      else $error("release in idle");
   a_safe_sticky: assert property (safe_state_out && !ack_in |=> safe_state_out)
      else $error("safe dropped");
   a_fault_held: assert property (fault_out != 3'h0 && !ack_in |=> fault_out != 3'h0)
      else $error("fault dropped");
   a_safe_cause: assert property ($rose(safe_state_out) |-> ##[0:1] fault_out != 3'h0)
      else $error("safe without cause");
   a_safe_quiet: assert property (safe_state_out [*3] |-> !pulse_generation_output_out)
      else $error("pulse in safe");
   a_idle_quiet: assert property (!enable_in [*3] |-> !pulse_generation_output_out)
      else $error("pulse in idle");
   a_pulse_period:
      assert property ((enable_in && !safe_state_out) [*3] ##0 $fell(pulse_generation_output_out)
         |-> hi_run_reg == cfg_in.interval - cfg_in.width) else $error("period wrong");
   a_release_range:
      assert property ($rose(release_out) |-> measured_delay_out >= cfg_in.delay_min
         && measured_delay_out <= cfg_in.delay_max && measured_width_out >= cfg_in.width_min
         && measured_width_out <= cfg_in.width_max) else $error("release out of range");
   cover property ($rose(release_out));
   cover property (fault_out.missing);
   cover property (fault_out.delay_bad);
   cover property (fault_out.width_bad);
endmodule
bind delayed_test_pulse_monitor delayed_test_pulse_monitor_checker #(.W(W)) u_checker (
   .clock_in(clock_in),
   .rstn_in(rstn_in),
   .enable_in(enable_in),
   .ack_in(ack_in),
   .sink_return_input_in(sink_return_input_in),
   .cfg_in(cfg_in),
   .pulse_generation_output_out(pulse_generation_output_out),
   .release_out(release_out),
   .safe_state_out(safe_state_out),
   .fault_out(fault_out),
   .measured_delay_out(measured_delay_out),
   .measured_width_out(measured_width_out)
);

/* test/echo_source.sv */
// Behavioural model of one delayed echo source
`timescale 1ns/100ps
module echo_source (
   input wire logic clock_in,
   input wire logic pulse_in,
   input wire logic on_in,
   input wire logic [5:0] delay_in,
   output logic echo_out
);
   logic [63:0] hist_reg;
   // Both edges go through one shift, so the shape is kept
   always_ff @(posedge clock_in) begin
      hist_reg <= {hist_reg[62:0], pulse_in};
   end
   // With on_in low the line carries no signal at all
   assign echo_out = on_in ? hist_reg[delay_in] : 1'b0;
endmodule

/* test/delayed_test_pulse_monitor_test.sv */
// Self-checking bench for the delayed test pulse monitor
`timescale 1ns/100ps
module delayed_test_pulse_monitor_test;
   import pulse_monitor_pkg::*;
   logic clock_in = 1'b0, rstn_in = 1'b0, enable_in = 1'b0, ack_in = 1'b0, on = 1'b1;
   logic sink_return_input_in, pulse_generation_output_out, release_out, safe_state_out, mid;
   logic [5:0] d1 = 6'h00, d2 = 6'h00;
   logic [23:0] measured_delay_out, measured_width_out;
   monitor_cfg_t cfg_in = '0;
   fault_t fault_out;
   int n_fail = 0, checked = 0;
   always #10 clock_in = ~clock_in;
   delayed_test_pulse_monitor u_dut (
      .clock_in(clock_in),
      .rstn_in(rstn_in),
      .enable_in(enable_in),
      .cfg_in(cfg_in),
      .ack_in(ack_in),
      .sink_return_input_in(sink_return_input_in),
      .pulse_generation_output_out(pulse_generation_output_out),
      .release_out(release_out),
      .safe_state_out(safe_state_out),
      .fault_out(fault_out),
      .measured_delay_out(measured_delay_out),
      .measured_width_out(measured_width_out)
   );
   echo_source u_src1 (.clock_in, .pulse_in(pulse_generation_output_out), .on_in(on),
      .delay_in(d1), .echo_out(mid));
   echo_source u_src2 (.clock_in, .pulse_in(mid), .on_in(on), .delay_in(d2),
      .echo_out(sink_return_input_in));
   task automatic chk(input string n, input logic [7:0] e, g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %0h seen %0h", n, e, g);
      end
   endtask
   task automatic chb(input string n, input logic e, g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic end_sim;
      if (n_fail == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Restart from idle with delays a, b; delay window starts off after a + b
   task automatic go(input logic [5:0] a, b, input logic [23:0] off, wl);
      @(negedge clock_in);
      {d1, d2, enable_in, ack_in} = {a, b, 2'b01};
      cfg_in = '{24'h00_0064, 24'h00_000A, a + b + off, a + b + off + 24'h00_000A, wl,
         wl + 24'h00_0004};
      @(negedge clock_in);
      {enable_in, ack_in} = 2'b10;
      repeat (300) @(negedge clock_in);
   endtask
   task automatic s_gen;
      int lo = 0;
      go(6'h02, 6'h01, 24'h00_0000, 24'h00_0008);
      repeat (100) begin
         @(negedge clock_in);
         lo += !pulse_generation_output_out;
      end
      chk("low cycles", 8'h0A, 8'(lo));
      chb("release short", 1'b1, release_out);
      // Summed delay 3, one register in each source, two synchroniser stages
      chk("measured delay", 8'h07, 8'(measured_delay_out));
      chk("measured width", 8'h0A, 8'(measured_width_out));
   endtask
   task automatic s_long;
      go(6'h0C, 6'h06, 24'h00_0000, 24'h00_0008);
      chb("release long", 1'b1, release_out);
      chb("safe long", 1'b0, safe_state_out);
   endtask
   task automatic s_late;
      go(6'h03, 6'h02, 24'h00_0028, 24'h00_0008);
      chk("fault delay", 8'h02, 8'(fault_out));
      chb("release delay", 1'b0, release_out);
      repeat (300) @(negedge clock_in);
      chb("safe held", 1'b1, safe_state_out);
   endtask
   task automatic s_miss;
      on = 1'b0;
      go(6'h03, 6'h02, 24'h00_0000, 24'h00_0008);
      chk("fault missing", 8'h04, 8'(fault_out));
      on = 1'b1;
   endtask
   task automatic s_wide;
      go(6'h03, 6'h02, 24'h00_0000, 24'h00_0014);
      chk("fault width", 8'h01, 8'(fault_out));
   endtask
   initial begin
      repeat (4) @(negedge clock_in);
      rstn_in = 1'b1;
      s_gen();
      s_long();
      s_late();
      s_miss();
      s_wide();
      ack_in = 1'b1;
      @(negedge clock_in);
      chb("safe after ack", 1'b0, safe_state_out);
      end_sim();
   end
endmodule
